// ===== rcl_consts.svh
// Offsets, field positions, codes and reset values of the reset configuration latches
`ifndef RCL_CONSTS_SVH
`define RCL_CONSTS_SVH

// ****************************************
// Register indices, byte address is four times the index
// ****************************************
`define RCL_NUM_BYTES        4
`define RCL_IDX_LOW_DRIVE    4'h0
`define RCL_IDX_UPPER_DRIVE  4'h1
`define RCL_IDX_PIN_DEBUG    4'h2
`define RCL_IDX_CLK_ECC_DBG  4'h3
`define RCL_IDX_APPLIED      4'h4
`define RCL_IDX_STATUS       4'h5
`define RCL_IDX_LSB          2
`define RCL_IDX_MSB          5

// ****************************************
// Field positions
// ****************************************
`define RCL_NUM_PORTS        9
`define RCL_PINS_PER_PORT    8
`define RCL_EXT_RST_BIT      7
`define RCL_DBG_EN_BIT       6
`define RCL_PHS_MSB          7
`define RCL_PHS_LSB          4
`define RCL_ECC_BIT          3
`define RCL_DPS_MSB          2
`define RCL_DPS_LSB          1
`define RCL_BOOT_BIT         0
`define RCL_PENDING_BIT      16

// ****************************************
// Codes
// ****************************************
`define RCL_RDM_HIZ_ANALOG   2'h0
`define RCL_RDM_HIZ_DIGITAL  2'h1
`define RCL_RDM_PULL_UP      2'h2
`define RCL_RDM_PULL_DOWN    2'h3
`define RCL_DPS_JTAG5        2'h0
`define RCL_DPS_JTAG4        2'h1
`define RCL_DPS_SWD          2'h2
`define RCL_DPS_OFF          2'h3
`define RCL_RESP_OKAY        2'h0
`define RCL_RESP_SLVERR      2'h2

// ****************************************
// Factory values
// ****************************************
`define RCL_DEF_BYTE0        8'h00
`define RCL_DEF_BYTE1        8'h00
`define RCL_DEF_BYTE2        8'h40
`define RCL_DEF_BYTE3        8'h0A
`define RCL_WEAR_MAX         16'hFFFF

`endif

// ===== rcl_pkg.sv
// Types shared by the reset configuration latch modules
`include "rcl_consts.svh"

package rcl_pkg;

   typedef logic [1:0] rcl_drive_mode_t;

   typedef logic [`RCL_NUM_BYTES-1:0][7:0] rcl_latch_t;

   typedef struct packed {
      logic analog_en;
      logic dig_in_en;
      logic pull_up;
      logic pull_down;
   } rcl_pin_ctl_t;

   typedef struct packed {
      logic jtag5_en;
      logic jtag4_en;
      logic swd_en;
   } rcl_dbg_ports_t;

   typedef struct packed {
      logic [3:0]                             phase_delay;
      logic                                   flash_ecc_enable;
      logic [1:0]                             debug_port_select;
      logic                                   boot_speed_select;
      logic                                   ext_reset_pin_select;
      logic                                   debug_access_enable;
      rcl_drive_mode_t [`RCL_NUM_PORTS-1:0]   port_mode;
   } rcl_settings_t;

endpackage

// ===== rcl_pin_expand.sv
// Spreads each port's reset drive mode over all pins of that port
`timescale 1ns/100ps
`default_nettype none
`include "rcl_consts.svh"

module rcl_pin_expand
#(
   parameter int NUM_PORTS = `RCL_NUM_PORTS,
   parameter int PINS      = `RCL_PINS_PER_PORT
)
(
   input  wire logic                                          aclk,
   input  wire logic                                          aresetn,
   input  wire logic                                          ce,
   input  wire rcl_pkg::rcl_drive_mode_t [NUM_PORTS-1:0]      port_mode,
   output var  rcl_pkg::rcl_pin_ctl_t [NUM_PORTS*PINS-1:0]    pin_ctl
);
   import rcl_pkg::*;

   rcl_pin_ctl_t [NUM_PORTS*PINS-1:0] pin_nxt;

   for (genvar i = 0; i < NUM_PORTS*PINS; i++)
   begin : g_pin
      always_comb
      begin
         pin_nxt[i] = '0;
         case (port_mode[i/PINS])
            `RCL_RDM_HIZ_ANALOG:  pin_nxt[i].analog_en = 1'b1;
            `RCL_RDM_HIZ_DIGITAL: pin_nxt[i].dig_in_en = 1'b1;
            `RCL_RDM_PULL_UP:     pin_nxt[i].pull_up   = 1'b1;
            `RCL_RDM_PULL_DOWN:   pin_nxt[i].pull_down = 1'b1;
            default:              pin_nxt[i].analog_en = 1'b1;
         endcase
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         // Safe analog high impedance while in reset
         for (int k = 0; k < NUM_PORTS*PINS; k++)
         begin
            pin_ctl[k] <= '{analog_en: 1'b1, default: 1'b0};
         end
      end
      else if (ce)
      begin
         pin_ctl <= pin_nxt;
      end
   end

endmodule
`default_nettype wire

// ===== rcl_sys_decode.sv
// Decodes reset pin, debug, flash ECC and clock settings into control levels
`timescale 1ns/100ps
`default_nettype none
`include "rcl_consts.svh"

module rcl_sys_decode
(
   input  wire logic                    aclk,
   input  wire logic                    aresetn,
   input  wire logic                    ce,
   input  wire rcl_pkg::rcl_settings_t  settings,
   input  wire logic                    shared_reset_capable_pin,
   output var  logic                    ext_reset_req,
   output var  logic                    shared_pin_gpio_in,
   output var  logic                    debug_access_enable,
   output var  rcl_pkg::rcl_dbg_ports_t dbg_ports,
   output var  logic                    flash_ecc_enable,
   output var  logic                    ecc_area_user_en,
   output var  logic [3:0]              digital_clock_phase_delay,
   output var  logic                    boot_speed_select
);
   import rcl_pkg::*;

   rcl_dbg_ports_t dbg_nxt;

   always_comb
   begin
      dbg_nxt = '0;
      case (settings.debug_port_select)
         `RCL_DPS_JTAG5: dbg_nxt.jtag5_en = 1'b1;
         `RCL_DPS_JTAG4: dbg_nxt.jtag4_en = 1'b1;
         `RCL_DPS_SWD:   dbg_nxt.swd_en   = 1'b1;
         default:        dbg_nxt          = '0;
      endcase
      if (!settings.debug_access_enable)
      begin
         dbg_nxt = '0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ext_reset_req             <= 1'b0;
         shared_pin_gpio_in        <= 1'b0;
         debug_access_enable       <= 1'b0;
         dbg_ports                 <= '0;
         flash_ecc_enable          <= 1'b0;
         ecc_area_user_en          <= 1'b0;
         digital_clock_phase_delay <= 4'h0;
         boot_speed_select         <= 1'b0;
      end
      else if (ce)
      begin
         ext_reset_req             <= settings.ext_reset_pin_select & ~shared_reset_capable_pin;
         shared_pin_gpio_in        <= ~settings.ext_reset_pin_select & shared_reset_capable_pin;
         debug_access_enable       <= settings.debug_access_enable;
         dbg_ports                 <= dbg_nxt;
         flash_ecc_enable          <= settings.flash_ecc_enable;
         ecc_area_user_en          <= ~settings.flash_ecc_enable;
         digital_clock_phase_delay <= settings.phase_delay;
         boot_speed_select         <= settings.boot_speed_select;
      end
   end

endmodule
`default_nettype wire

// ===== rcl_top.sv
// Reset configuration latches with AXI4-Lite access and applied settings
//
// Operation
// - Four latch bytes configure device at reset
// - Two-bit code picks port reset drive
// - All pins of a port share mode
// - Select bit makes shared pin reset input
// - Debug enable bit gates debug access
// - Two-bit field picks debug port type
// - ECC bit reserves or frees ECC area
// - Last byte nibble sets clock phase delay
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
`include "rcl_consts.svh"

module rcl_top
#(
   parameter int         ADDR_W          = 8,
   parameter logic       DEF_EXT_RESET   = 1'b0,
   parameter logic [3:0] DEF_PHASE_DELAY = 4'h0,
   parameter logic       DEF_BOOT_SPEED  = 1'b0
)
(
   input  wire logic                                                          aclk,
   input  wire logic                                                          aresetn,
   input  wire logic                                                          ce,
   input  wire logic                                                          por_n,
   input  wire logic                                                          shared_reset_capable_pin,
   input  wire logic [ADDR_W-1:0]                                             awaddr,
   input  wire logic [2:0]                                                    awprot,
   input  wire logic                                                          awvalid,
   output var  logic                                                          awready,
   input  wire logic [31:0]                                                   wdata,
   input  wire logic [3:0]                                                    wstrb,
   input  wire logic                                                          wvalid,
   output var  logic                                                          wready,
   output var  logic [1:0]                                                    bresp,
   output var  logic                                                          bvalid,
   input  wire logic                                                          bready,
   input  wire logic [ADDR_W-1:0]                                             araddr,
   input  wire logic [2:0]                                                    arprot,
   input  wire logic                                                          arvalid,
   output var  logic                                                          arready,
   output var  logic [31:0]                                                   rdata,
   output var  logic [1:0]                                                    rresp,
   output var  logic                                                          rvalid,
   input  wire logic                                                          rready,
   output wire rcl_pkg::rcl_pin_ctl_t [`RCL_NUM_PORTS*`RCL_PINS_PER_PORT-1:0] pin_ctl,
   output wire logic                                                          ext_reset_req,
   output wire logic                                                          shared_pin_gpio_in,
   output wire logic                                                          debug_access_enable,
   output wire rcl_pkg::rcl_dbg_ports_t                                       dbg_ports,
   output wire logic                                                          flash_ecc_enable,
   output wire logic                                                          ecc_area_user_en,
   output wire logic [3:0]                                                    digital_clock_phase_delay,
   output wire logic                                                          boot_speed_select
);
   import rcl_pkg::*;

   // ****************************************
   // Declarations
   // ****************************************
   typedef enum logic { WR_COLLECT, WR_RESP } rcl_wr_state_t;
   typedef enum logic { RD_IDLE, RD_DATA } rcl_rd_state_t;

   // Package dependent fields merged into the factory bytes, one byte per lane
   localparam rcl_latch_t FACTORY = {
      (`RCL_DEF_BYTE3 & 8'h0E) | {DEF_PHASE_DELAY, 4'h0} | {7'h00, DEF_BOOT_SPEED},
      (`RCL_DEF_BYTE2 & 8'h7F) | {DEF_EXT_RESET, 7'h00},
      `RCL_DEF_BYTE1,
      `RCL_DEF_BYTE0
   };

   rcl_wr_state_t wst_r;
   rcl_wr_state_t wst_nxt;
   logic          aw_have_r;
   logic          aw_have_nxt;
   logic          w_have_r;
   logic          w_have_nxt;
   logic [3:0]    aw_idx_r;
   logic [3:0]    aw_idx_nxt;
   logic          aw_map_r;
   logic          aw_map_nxt;
   logic [7:0]    wbyte_r;
   logic [7:0]    wbyte_nxt;
   logic          wlane_r;
   logic          wlane_nxt;
   logic          awready_nxt;
   logic          wready_nxt;
   logic          bvalid_nxt;
   logic [1:0]    bresp_nxt;
   logic          wr_fire;

   rcl_rd_state_t rst_r;
   rcl_rd_state_t rst_nxt;
   logic          arready_nxt;
   logic          rvalid_nxt;
   logic [31:0]   rdata_nxt;
   logic [1:0]    rresp_nxt;

   rcl_latch_t    latch_r;
   rcl_latch_t    latch_nxt;
   rcl_latch_t    snapshot_r;
   rcl_latch_t    snapshot_nxt;
   logic [15:0]   wear_cnt_r;
   logic [15:0]   wear_cnt_nxt;
   rcl_settings_t settings;

   // ****************************************
   // Address decode
   // ****************************************
   function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
      logic ok;
      ok = (a[`RCL_IDX_MSB:`RCL_IDX_LSB] <= `RCL_IDX_STATUS);
      if (a[ADDR_W-1:`RCL_IDX_MSB+1] != '0)
      begin
         ok = 1'b0;
      end
      return ok;
   endfunction

   function automatic logic [31:0] read_word(input logic [3:0] idx);
      logic [31:0] w;
      w = 32'h0000_0000;
      case (idx)
         `RCL_IDX_LOW_DRIVE:   w[7:0] = latch_r[0];
         `RCL_IDX_UPPER_DRIVE: w[7:0] = latch_r[1];
         `RCL_IDX_PIN_DEBUG:   w[7:0] = latch_r[2];
         `RCL_IDX_CLK_ECC_DBG: w[7:0] = latch_r[3];
         `RCL_IDX_APPLIED:     w      = snapshot_r;
         `RCL_IDX_STATUS:
         begin
            w[15:0]             = wear_cnt_r;
            w[`RCL_PENDING_BIT] = (latch_r != snapshot_r);
         end
         default:              w      = 32'h0000_0000;
      endcase
      return w;
   endfunction

   // ****************************************
   // Write channel
   // ****************************************
   always_comb
   begin
      wst_nxt     = wst_r;
      aw_have_nxt = aw_have_r;
      w_have_nxt  = w_have_r;
      aw_idx_nxt  = aw_idx_r;
      aw_map_nxt  = aw_map_r;
      wbyte_nxt   = wbyte_r;
      wlane_nxt   = wlane_r;
      bvalid_nxt  = bvalid;
      bresp_nxt   = bresp;
      wr_fire     = 1'b0;
      case (wst_r)
         WR_COLLECT:
         begin
            if (awvalid && awready)
            begin
               aw_have_nxt = 1'b1;
               aw_idx_nxt  = awaddr[`RCL_IDX_MSB:`RCL_IDX_LSB];
               aw_map_nxt  = addr_mapped(awaddr);
            end
            if (wvalid && wready)
            begin
               w_have_nxt = 1'b1;
               wbyte_nxt  = wdata[7:0];
               wlane_nxt  = wstrb[0];
            end
            // Address and data may arrive in either order
            if (aw_have_nxt && w_have_nxt)
            begin
               wr_fire     = aw_map_nxt;
               aw_have_nxt = 1'b0;
               w_have_nxt  = 1'b0;
               bvalid_nxt  = 1'b1;
               bresp_nxt   = aw_map_nxt ? `RCL_RESP_OKAY : `RCL_RESP_SLVERR;
               wst_nxt     = WR_RESP;
            end
         end
         WR_RESP:
         begin
            if (bready)
            begin
               bvalid_nxt = 1'b0;
               wst_nxt    = WR_COLLECT;
            end
         end
         default:
         begin
            wst_nxt = WR_COLLECT;
         end
      endcase
      awready_nxt = (wst_nxt == WR_COLLECT) && !aw_have_nxt;
      wready_nxt  = (wst_nxt == WR_COLLECT) && !w_have_nxt;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         wst_r     <= WR_COLLECT;
         aw_have_r <= 1'b0;
         w_have_r  <= 1'b0;
         aw_idx_r  <= 4'h0;
         aw_map_r  <= 1'b0;
         wbyte_r   <= 8'h00;
         wlane_r   <= 1'b0;
         awready   <= 1'b0;
         wready    <= 1'b0;
         bvalid    <= 1'b0;
         bresp     <= `RCL_RESP_OKAY;
      end
      else if (ce)
      begin
         wst_r     <= wst_nxt;
         aw_have_r <= aw_have_nxt;
         w_have_r  <= w_have_nxt;
         aw_idx_r  <= aw_idx_nxt;
         aw_map_r  <= aw_map_nxt;
         wbyte_r   <= wbyte_nxt;
         wlane_r   <= wlane_nxt;
         awready   <= awready_nxt;
         wready    <= wready_nxt;
         bvalid    <= bvalid_nxt;
         bresp     <= bresp_nxt;
      end
   end

   // ****************************************
   // Read channel
   // ****************************************
   always_comb
   begin
      rst_nxt    = rst_r;
      rvalid_nxt = rvalid;
      rdata_nxt  = rdata;
      rresp_nxt  = rresp;
      case (rst_r)
         RD_IDLE:
         begin
            if (arvalid && arready)
            begin
               rvalid_nxt = 1'b1;
               rdata_nxt  = addr_mapped(araddr) ? read_word(araddr[`RCL_IDX_MSB:`RCL_IDX_LSB]) : 32'h0000_0000;
               rresp_nxt  = addr_mapped(araddr) ? `RCL_RESP_OKAY : `RCL_RESP_SLVERR;
               rst_nxt    = RD_DATA;
            end
         end
         RD_DATA:
         begin
            if (rready)
            begin
               rvalid_nxt = 1'b0;
               rst_nxt    = RD_IDLE;
            end
         end
         default:
         begin
            rst_nxt = RD_IDLE;
         end
      endcase
      arready_nxt = (rst_nxt == RD_IDLE);
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rst_r   <= RD_IDLE;
         arready <= 1'b0;
         rvalid  <= 1'b0;
         rdata   <= 32'h0000_0000;
         rresp   <= `RCL_RESP_OKAY;
      end
      else if (ce)
      begin
         rst_r   <= rst_nxt;
         arready <= arready_nxt;
         rvalid  <= rvalid_nxt;
         rdata   <= rdata_nxt;
         rresp   <= rresp_nxt;
      end
   end

   // ****************************************
   // Latch array and applied copy
   // ****************************************
   always_comb
   begin
      latch_nxt    = latch_r;
      wear_cnt_nxt = wear_cnt_r;
      if (!por_n)
      begin
         latch_nxt    = FACTORY;
         wear_cnt_nxt = 16'h0000;
      end
      else if (wr_fire && wlane_nxt && aw_idx_nxt <= `RCL_IDX_CLK_ECC_DBG)
      begin
         if (latch_r[aw_idx_nxt[1:0]] != wbyte_nxt)
         begin
            latch_nxt[aw_idx_nxt[1:0]] = wbyte_nxt;
            if (wear_cnt_r != `RCL_WEAR_MAX)
            begin
               wear_cnt_nxt = wear_cnt_r + 16'h0001;
            end
         end
      end
   end

   // capture only while reset is held
   always_comb
   begin
      snapshot_nxt = aresetn ? snapshot_r : latch_r;
   end

   always_ff @(posedge aclk)
   begin
      if (!por_n || ce)
      begin
         latch_r    <= latch_nxt;
         wear_cnt_r <= wear_cnt_nxt;
      end
   end

   // Capture ignores ce so reset always applies fresh settings
   always_ff @(posedge aclk)
   begin
      if (!aresetn || ce)
      begin
         snapshot_r <= snapshot_nxt;
      end
   end

   // ****************************************
   // Field extraction
   // ****************************************
   always_comb
   begin
      settings.phase_delay          = snapshot_r[3][`RCL_PHS_MSB:`RCL_PHS_LSB];
      settings.flash_ecc_enable     = snapshot_r[3][`RCL_ECC_BIT];
      settings.debug_port_select    = snapshot_r[3][`RCL_DPS_MSB:`RCL_DPS_LSB];
      settings.boot_speed_select    = snapshot_r[3][`RCL_BOOT_BIT];
      settings.ext_reset_pin_select = snapshot_r[2][`RCL_EXT_RST_BIT];
      settings.debug_access_enable  = snapshot_r[2][`RCL_DBG_EN_BIT];
      // ports 0..3, 4..7, then 8
      settings.port_mode            = {snapshot_r[2][1:0], snapshot_r[1], snapshot_r[0]};
   end

   rcl_pin_expand u_pin_expand
   (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .ce        (ce),
      .port_mode (settings.port_mode),
      .pin_ctl   (pin_ctl)
   );

   rcl_sys_decode u_sys_decode
   (
      .aclk                      (aclk),
      .aresetn                   (aresetn),
      .ce                        (ce),
      .settings                  (settings),
      .shared_reset_capable_pin  (shared_reset_capable_pin),
      .ext_reset_req             (ext_reset_req),
      .shared_pin_gpio_in        (shared_pin_gpio_in),
      .debug_access_enable       (debug_access_enable),
      .dbg_ports                 (dbg_ports),
      .flash_ecc_enable          (flash_ecc_enable),
      .ecc_area_user_en          (ecc_area_user_en),
      .digital_clock_phase_delay (digital_clock_phase_delay),
      .boot_speed_select         (boot_speed_select)
   );

endmodule
`default_nettype wire

// ===== rcl_top_chk.sv
// Port checks for the reset configuration latch top
`timescale 1ns/100ps
`default_nettype none
`include "rcl_consts.svh"
module rcl_top_chk
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic debug_access_enable,
   input wire logic flash_ecc_enable,
   input wire logic ecc_area_user_en,
   input wire rcl_pkg::rcl_dbg_ports_t dbg_ports,
   input wire rcl_pkg::rcl_pin_ctl_t [`RCL_NUM_PORTS*`RCL_PINS_PER_PORT-1:0] pin_ctl
);
   import rcl_pkg::*;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_wr_open; !bvalid && awready && wready; endsequence
   a_wr_answer: assert property (awvalid && awready && wvalid && wready |=> bvalid && !awready)
      else $error("no write answer");
   a_wr_release: assert property (bvalid && bready |=> s_wr_open) else $error("write stuck");
   a_b_holds: assert property (bvalid && !bready |=> bvalid) else $error("response dropped");
   a_rd_answer: assert property (arvalid && arready |=> rvalid && !arready) else $error("no read answer");
   a_rd_release: assert property (rvalid && rready |=> !rvalid && arready) else $error("read stuck");
   a_dbg_gated: assert property (!debug_access_enable |-> dbg_ports == 3'h0) else $error("debug open");
   a_dbg_single: assert property ($onehot0(dbg_ports)) else $error("debug ports clash");
   a_ecc_split: assert property ($past(aresetn) |-> flash_ecc_enable != ecc_area_user_en)
      else $error("ecc area clash");
   // Two edges of grace: outputs load one edge after release
   a_apply_hold: assert property ($past(aresetn) && $past(aresetn, 2) |-> $stable(pin_ctl) && $stable(dbg_ports))
      else $error("settings moved");
   for (genvar k = 0; k < 72; k++)
   begin : g_pin
      a_port_same: assert property ($onehot(pin_ctl[k]) && pin_ctl[k] == pin_ctl[k/8*8])
         else $error("port pins differ");
   end
endmodule
bind rcl_top rcl_top_chk u_chk (.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bvalid, .bready, .arvalid,
   .arready, .rvalid, .rready, .debug_access_enable, .flash_ecc_enable, .ecc_area_user_en, .dbg_ports, .pin_ctl);
`default_nettype wire

// ===== rcl_prog_model.sv
// Latch programmer model, an AXI4-Lite master
`timescale 1ns/100ps
`default_nettype none
module rcl_prog_model
(
   input wire logic aclk,
   output var logic [7:0] awaddr,
   output var logic awvalid,
   input wire logic awready,
   output var logic [31:0] wdata,
   output wire logic [3:0] wstrb,
   output var logic wvalid,
   input wire logic wready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   output var logic bready,
   output var logic [7:0] araddr,
   output var logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic rvalid,
   output var logic rready
);
   // Slow mode raises ready late so held answers get seen
   bit slow = 1'h0;
   assign wstrb = 4'h1;
   initial {awaddr, wdata, araddr, awvalid, wvalid, bready, arvalid, rready} = '0;
   // Released lines flip so stale values never pass for data
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 2'h3, !slow};
      forever
      begin
         @(posedge aclk);
         if (awvalid && awready) {awvalid, awaddr} <= {1'h0, ~a};
         if (wvalid && wready) {wvalid, wdata} <= {1'h0, ~d};
         if (bvalid && bready) break;
         bready <= bready | bvalid;
      end
      r = bresp;
      bready <= 1'h0;
      @(posedge aclk);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      {araddr, arvalid, rready} <= {a, 1'h1, !slow};
      forever
      begin
         @(posedge aclk);
         if (arvalid && arready) {arvalid, araddr} <= {1'h0, ~a};
         if (rvalid && rready) break;
         rready <= rready | rvalid;
      end
      {d, r} = {rdata, rresp};
      rready <= 1'h0;
      @(posedge aclk);
   endtask
endmodule
`default_nettype wire

// ===== tb_top.sv
// Self-checking bench for the reset configuration latches
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin err_total++; \
   $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module tb_top;
   import rcl_pkg::*;
   logic aclk = 1'h0, aresetn, por_n, shared_reset_capable_pin, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, ext_reset_req, shared_pin_gpio_in, debug_access_enable;
   logic flash_ecc_enable, ecc_area_user_en, boot_speed_select;
   logic [7:0] awaddr, araddr, lm[4], ap[4], nv[4];
   logic [31:0] wdata, rdata, d;
   logic [3:0] wstrb, digital_clock_phase_delay;
   logic [1:0] bresp, rresp, r;
   rcl_pin_ctl_t [71:0] pin_ctl;
   rcl_dbg_ports_t dbg_ports;
   int err_total = 0, cmp_count = 0, seed = 32'h0000_e415, wc = 0;
   initial forever #4 aclk = ~aclk;
   rcl_top u_dut (.aclk, .aresetn, .ce(1'h1), .por_n, .shared_reset_capable_pin, .awaddr, .awprot(3'h0), .awvalid,
      .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot(3'h0), .arvalid,
      .arready, .rdata, .rresp, .rvalid, .rready, .pin_ctl, .ext_reset_req, .shared_pin_gpio_in,
      .debug_access_enable, .dbg_ports, .flash_ecc_enable, .ecc_area_user_en, .digital_clock_phase_delay,
      .boot_speed_select);
   rcl_prog_model u_prog (.aclk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
      .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
   task automatic print_verdict;
      $display("mismatches %0d, comparisons %0d", err_total, cmp_count);
      if (err_total == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic rst(input logic pwr);
      {aresetn, por_n} <= {1'h0, ~pwr};
      repeat (8) @(posedge aclk);
      {aresetn, por_n} <= 2'h3;
      repeat (3) @(posedge aclk);
      ap = lm;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      u_prog.rd(a, d, r);
      `CHK("rdata", e, d)
      `CHK("rresp", er, r)
   endtask
   task automatic chk_out;
      logic [23:0] v;
      logic p;
      v = {ap[2], ap[1], ap[0]};
      p = shared_reset_capable_pin;
      for (int k = 0; k < 72; k++)
         `CHK("pin_ctl", 4'h8 >> v[2*(k/8)+:2], pin_ctl[k])
      `CHK("dbg", ap[2][6] && ap[3][2:1] != 2'h3 ? 3'h4 >> ap[3][2:1] : 3'h0, dbg_ports)
      `CHK("dbe", ap[2][6], debug_access_enable)
      `CHK("ecc", {ap[3][3], ~ap[3][3]}, {flash_ecc_enable, ecc_area_user_en})
      `CHK("phs", {ap[3][7:4], ap[3][0]}, {digital_clock_phase_delay, boot_speed_select})
      `CHK("external_reset_pin", {ap[2][7] & ~p, ~ap[2][7] & p}, {ext_reset_req, shared_pin_gpio_in})
   endtask
   initial
   begin
      {aresetn, por_n, shared_reset_capable_pin} = 3'h0;
      lm = '{8'h00, 8'h00, 8'h40, 8'h0A};
      @(posedge aclk);
      rst(1'h1);
      for (int j = 0; j < 4; j++)
         rchk(8'(4*j), {24'h00_0000, lm[j]}, 2'h0);
      chk_out;
      // Loop index walks every drive, debug port and pin select code
      for (int i = 0; i < 8; i++)
      begin
         u_prog.slow = i[0];
         shared_reset_capable_pin <= 1'($random(seed));
         for (int j = 0; j < 4; j++)
            nv[j] = 8'($random(seed));
         nv[0][1:0] = 2'(i);
         nv[3][2:1] = 2'(i);
         nv[2][7:6] = {i[1], i != 5};
         for (int j = 0; j < 4; j++)
         begin
            u_prog.wr(8'(4*j), {24'h00_0000, nv[j]}, r);
            `CHK("bresp", 2'h0, r)
            wc += int'(nv[j] != lm[j]);
            lm[j] = nv[j];
            rchk(8'(4*j), {24'h00_0000, lm[j]}, 2'h0);
         end
         chk_out;
         rchk(8'h10, {ap[3], ap[2], ap[1], ap[0]}, 2'h0);
         rchk(8'h14, {15'h0000, lm != ap, 16'(wc)}, 2'h0);
         rst(1'h0);
         chk_out;
      end
      rchk(8'h18, 32'h0000_0000, 2'h2);
      u_prog.wr(8'h10, 32'h0000_00FF, r);
      `CHK("ro_bresp", 2'h0, r)
      rchk(8'h10, {ap[3], ap[2], ap[1], ap[0]}, 2'h0);
      // Same value again must not count as a rewrite
      u_prog.wr(8'h00, {24'h00_0000, lm[0]}, r);
      `CHK("same_bresp", 2'h0, r)
      rchk(8'h14, {16'h0000, 16'(wc)}, 2'h0);
      print_verdict;
   end
   initial
   begin
      #20us;
      err_total++;
      print_verdict;
   end
endmodule
`default_nettype wire
